//--- shared/tats_pkg.sv
/*
 * Constants for the touch converter trigger and status block: register
 * offsets, field positions, reset values and trigger codes.
 * Assumes a 32-bit register bus with byte addresses and one clock.
 */
//==================================================================
// Function
// - trigger code 000: only a software start begins conversions.
// - codes 001, 010, 011: external rising, falling or any edge.
// - code 101: trigger every interval plus one conversion periods.
// - interval field ignored outside the periodic trigger code.
// - code 110 runs sequences back to back; 111 never written.
// - hold lasts hold field plus one periods, zero gives two.
// - a one in set register bits 5..0 enables that channel.
// - a one in clear register bits 5..0 disables that channel.
// - channel state register shows one per enabled channel.
// - done bits show enabled channels whose conversion completed.
// - per channel overrun bits latch until status is read.
// - result flag sets on conversion, clears on latest result read.
// - any overrun flag latches until status is read.
// - count end sets at zero, clears on counter writes.
// - both empty reads one exactly when both counters are zero.
// - touch made latches, clears on status read, zero if off.
// - touch lost latches, clears on status read, zero if off.
// - conversion clock is master clock over twice divider plus one.
// - touch mode shows channels 0 to 3 enabled in channel state and done bits; chEnabled keeps software enables.
// - latest result loads at every conversion end and holds.
package tats_pkg;
    //==============================================================
    // register map
    localparam logic [7:0] OFS_TRIG = 8'h08;
    localparam logic [7:0] OFS_HOLD = 8'h0C;
    localparam logic [7:0] OFS_CHSET = 8'h10;
    localparam logic [7:0] OFS_CHCLR = 8'h14;
    localparam logic [7:0] OFS_CHSTATE = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_LATEST = 8'h20;
    //==============================================================
    // field positions
    localparam int TRIG_SEL_LSB = 0;
    localparam int TRIG_IVL_LSB = 16;
    localparam int HOLD_LSB = 24;
    localparam int ST_OVR_LSB = 8;
    localparam int ST_RES_WAIT = 16;
    localparam int ST_ANY_OVR = 17;
    localparam int ST_CNT_END = 18;
    localparam int ST_BOTH_EMPTY = 19;
    localparam int ST_MADE = 20;
    localparam int ST_LOST = 21;
    //==============================================================
    // sizes, reset values, responses
    localparam int CH_N = 6;
    localparam logic [CH_N-1:0] TOUCH_CH_MASK = 6'h0F;
    localparam logic [4:0] HOLD_MIN = 5'h02;
    localparam logic [31:0] STATUS_RST = 32'h000C0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    //==============================================================
    // trigger select codes, in code order
    typedef enum logic [2:0] {
        TRG_SW, TRG_RISE, TRG_FALL, TRG_ANY,
        TRG_PEN, TRG_PERIOD, TRG_CONT, TRG_RSVD
    } tats_trig_t;
endpackage

//--- rtl/tats_ctrl.sv
/*
 * Trigger selection, periodic timer, touch hold timing, channel enables
 * and sticky status of a touch screen converter, with an AXI4-Lite
 * register slave.
 * Assumes the mode register, control start, sequencer, pointer counters
 * and debounce live elsewhere on the same clock; trigger and pen pins
 * arrive asynchronously.
 */
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
module tats_ctrl
    import tats_pkg::*;
#(
    parameter int RES_W = 10,
    parameter int DIV_W = 6
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic extTrigPin,
    input wire logic penTouchPin,
    input wire logic touchOnlyMode,
    input wire logic touchSenseEn,
    input wire logic [DIV_W-1:0] clockDivider,
    input wire logic swStart,
    input wire logic seqDone,
    input wire logic holdStart,
    input wire logic [CH_N-1:0] convDoneIn,
    input wire logic [RES_W-1:0] resultIn,
    input wire logic rxCountZero,
    input wire logic rxNextZero,
    input wire logic rxCountWrite,
    output logic seqStart,
    output logic holdActive,
    output logic convTick,
    output logic [CH_N-1:0] chEnabled
);
    //==============================================================
    // state
    typedef struct packed {
        logic awFree;
        logic [7:0] awAddr;
        logic wFree;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic arFree, rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [2:0] trigSel;
        logic [15:0] trigIvl;
        logic [3:0] holdTime;
        logic [CH_N-1:0] chEn, convDone, chOvr;
        logic resWait, anyOvr, cntEnd, bothEmpty;
        logic penMade, penLost;
        logic [RES_W-1:0] latest;
        logic busy, seqStart;
        logic [DIV_W:0] divCnt;
        logic convTick;
        logic [15:0] periodCnt;
        logic [4:0] holdCnt;
        logic holdActive, rxZeroPrev;
        logic extS1, extS2, extPrev;
        logic penS1, penS2, penPrev;
    } tats_state_t;

    localparam tats_state_t ST_RST = '{
        awFree: 1'b1,
        wFree: 1'b1,
        arFree: 1'b1,
        cntEnd: STATUS_RST[ST_CNT_END],
        bothEmpty: STATUS_RST[ST_BOTH_EMPTY],
        rxZeroPrev: 1'b1,
        default: '0
    };

    tats_state_t state_ff;
    tats_state_t nxt_state;

    logic wrFire, rdFire, srRead, lcdRead;
    logic extRise, extFall, penRise, penFall;
    logic periodHit, hwTrig, startNow;
    logic [CH_N-1:0] chEnEff;
    logic [31:0] statusWord, rdWord, trigWord, holdWord, trigMerged;
    logic [1:0] rdResp;

    // byte-lane merge so partial writes keep the other lanes
    function automatic logic [31:0] tats_merge(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = oldVal;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return res;
    endfunction

    //==============================================================
    // bus events and pin edges
    assign wrFire = !state_ff.awFree && !state_ff.wFree
        && !state_ff.bValid;
    assign rdFire = state_ff.arFree && arvalid;
    assign srRead = rdFire && araddr == OFS_STATUS;
    assign lcdRead = rdFire && araddr == OFS_LATEST;
    // only the second sync stage is looked at
    assign extRise = state_ff.extS2 && !state_ff.extPrev;
    assign extFall = !state_ff.extS2 && state_ff.extPrev;
    assign penRise = state_ff.penS2 && !state_ff.penPrev;
    assign penFall = !state_ff.penS2 && state_ff.penPrev;
    // touch mode adds channels 0..3 on top of software enables
    assign chEnEff = state_ff.chEn
        | (touchOnlyMode ? TOUCH_CH_MASK : '0);
    // timer only meaningful on a conversion clock tick
    assign periodHit = state_ff.convTick
        && state_ff.periodCnt == state_ff.trigIvl;
    assign trigWord = {state_ff.trigIvl, 13'h0, state_ff.trigSel};
    assign holdWord = {4'h0, state_ff.holdTime, 24'h0};
    assign trigMerged = tats_merge(trigWord, state_ff.wData, state_ff.wStrb);

    //==============================================================
    // trigger source selection
    always_comb begin
        case (tats_trig_t'(state_ff.trigSel))
            TRG_RISE: hwTrig = extRise;
            TRG_FALL: hwTrig = extFall;
            TRG_ANY: hwTrig = extRise || extFall;
            TRG_PEN: hwTrig = penRise && touchSenseEn;
            TRG_PERIOD: hwTrig = periodHit;
            TRG_CONT: hwTrig = 1'b1;
            default: hwTrig = 1'b0;
        endcase
        // a running sequence swallows every trigger
        startNow = (swStart || hwTrig) && !state_ff.busy;
    end

    //==============================================================
    // status word and read mux
    always_comb begin
        statusWord = '0;
        statusWord[CH_N-1:0] = state_ff.convDone & chEnEff;
        statusWord[ST_OVR_LSB +: CH_N] = state_ff.chOvr;
        statusWord[ST_RES_WAIT] = state_ff.resWait;
        statusWord[ST_ANY_OVR] = state_ff.anyOvr;
        statusWord[ST_CNT_END] = state_ff.cntEnd;
        statusWord[ST_BOTH_EMPTY] = state_ff.bothEmpty;
        statusWord[ST_MADE] = state_ff.penMade;
        statusWord[ST_LOST] = state_ff.penLost;
        rdWord = '0;
        rdResp = RESP_OKAY;
        if (araddr == OFS_TRIG) begin
            rdWord = trigWord;
        end else if (araddr == OFS_HOLD) begin
            rdWord = holdWord;
        end else if (araddr == OFS_CHSTATE) begin
            rdWord[CH_N-1:0] = chEnEff;
        end else if (araddr == OFS_STATUS) begin
            rdWord = statusWord;
        end else if (araddr == OFS_LATEST) begin
            rdWord[RES_W-1:0] = state_ff.latest;
        end else if (araddr == OFS_CHSET || araddr == OFS_CHCLR) begin
            rdWord = '0;
        end else begin
            rdResp = RESP_SLVERR;
        end
    end

    //==============================================================
    // next state
    always_comb begin
        nxt_state = state_ff;
        // write address and data taken independently
        if (state_ff.awFree && awvalid) begin
            nxt_state.awFree = 1'b0;
            nxt_state.awAddr = awaddr;
        end
        if (state_ff.wFree && wvalid) begin
            nxt_state.wFree = 1'b0;
            nxt_state.wData = wdata;
            nxt_state.wStrb = wstrb;
        end
        if (state_ff.bValid && bready) begin
            nxt_state.bValid = 1'b0;
        end
        if (wrFire) begin
            nxt_state.awFree = 1'b1;
            nxt_state.wFree = 1'b1;
            nxt_state.bValid = 1'b1;
            nxt_state.bResp = RESP_OKAY;
            if (state_ff.awAddr == OFS_TRIG) begin
                nxt_state.trigIvl = trigMerged[31:TRIG_IVL_LSB];
                nxt_state.trigSel = trigMerged[TRIG_SEL_LSB +: 3];
            end else if (state_ff.awAddr == OFS_HOLD) begin
                if (state_ff.wStrb[3]) begin
                    nxt_state.holdTime = state_ff.wData[HOLD_LSB +: 4];
                end
            end else if (state_ff.awAddr == OFS_CHSET) begin
                if (state_ff.wStrb[0]) begin
                    nxt_state.chEn = state_ff.chEn
                        | state_ff.wData[CH_N-1:0];
                end
            end else if (state_ff.awAddr == OFS_CHCLR) begin
                if (state_ff.wStrb[0]) begin
                    nxt_state.chEn = state_ff.chEn
                        & ~state_ff.wData[CH_N-1:0];
                end
            end else if (state_ff.awAddr == OFS_CHSTATE
                    || state_ff.awAddr == OFS_STATUS
                    || state_ff.awAddr == OFS_LATEST) begin
                nxt_state.bResp = RESP_OKAY;
            end else begin
                nxt_state.bResp = RESP_SLVERR;
            end
        end
        // read answered one cycle after the address is taken
        if (rdFire) begin
            nxt_state.arFree = 1'b0;
            nxt_state.rValid = 1'b1;
            nxt_state.rData = rdWord;
            nxt_state.rResp = rdResp;
        end else if (state_ff.rValid && rready) begin
            nxt_state.rValid = 1'b0;
            nxt_state.arFree = 1'b1;
        end

        // conversion clock: 2*(divider+1) master clocks per period
        if (state_ff.divCnt == {clockDivider, 1'b1}) begin
            nxt_state.divCnt = '0;
            nxt_state.convTick = 1'b1;
        end else begin
            nxt_state.divCnt = state_ff.divCnt + 1'b1;
            nxt_state.convTick = 1'b0;
        end

        // periodic timer parked at zero in every other mode
        if (state_ff.trigSel != TRG_PERIOD) begin
            nxt_state.periodCnt = '0;
        end else if (periodHit) begin
            nxt_state.periodCnt = '0;
        end else if (state_ff.convTick) begin
            nxt_state.periodCnt = state_ff.periodCnt + 1'b1;
        end

        // touch hold window counted in conversion periods
        if (holdStart) begin
            nxt_state.holdActive = 1'b1;
            nxt_state.holdCnt = (state_ff.holdTime == 4'h0) ? HOLD_MIN
                : {1'b0, state_ff.holdTime} + 5'h01;
        end else if (state_ff.holdActive && state_ff.convTick) begin
            if (state_ff.holdCnt <= 5'h01) begin
                nxt_state.holdActive = 1'b0;
                nxt_state.holdCnt = '0;
            end else begin
                nxt_state.holdCnt = state_ff.holdCnt - 5'h01;
            end
        end

        // sequence handshake
        nxt_state.seqStart = startNow;
        if (startNow) begin
            nxt_state.busy = 1'b1;
        end else if (seqDone) begin
            nxt_state.busy = 1'b0;
        end

        // pin synchronisers
        nxt_state.extS1 = extTrigPin;
        nxt_state.extS2 = state_ff.extS1;
        nxt_state.extPrev = state_ff.extS2;
        nxt_state.penS1 = penTouchPin;
        nxt_state.penS2 = state_ff.penS1;
        nxt_state.penPrev = state_ff.penS2;
        nxt_state.rxZeroPrev = rxCountZero;

        // sticky flags: a set in the clearing cycle wins
        nxt_state.convDone = state_ff.convDone | convDoneIn;
        nxt_state.chOvr = (srRead ? '0 : state_ff.chOvr)
            | (convDoneIn & state_ff.convDone);
        nxt_state.anyOvr = (state_ff.anyOvr && !srRead)
            || (|convDoneIn && state_ff.resWait);
        nxt_state.resWait = (state_ff.resWait && !lcdRead)
            || |convDoneIn;
        if (|convDoneIn) begin
            nxt_state.latest = resultIn;
        end
        nxt_state.cntEnd = (state_ff.cntEnd && !rxCountWrite)
            || (rxCountZero && !state_ff.rxZeroPrev);
        nxt_state.bothEmpty = rxCountZero && rxNextZero;
        nxt_state.penMade = touchSenseEn && ((state_ff.penMade
            && !srRead) || penRise);
        nxt_state.penLost = touchSenseEn && ((state_ff.penLost
            && !srRead) || penFall);
    end

    // one register stage for all state; clkEn freezes everything except reset
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= ST_RST;
        end else if (clkEn) begin
            state_ff <= nxt_state;
        end
    end

    //==============================================================
    // outputs
    assign awready = state_ff.awFree;
    assign wready = state_ff.wFree;
    assign bvalid = state_ff.bValid;
    assign bresp = state_ff.bResp;
    assign arready = state_ff.arFree;
    assign rvalid = state_ff.rValid;
    assign rdata = state_ff.rData;
    assign rresp = state_ff.rResp;
    assign seqStart = state_ff.seqStart;
    assign holdActive = state_ff.holdActive;
    assign convTick = state_ff.convTick;
    assign chEnabled = state_ff.chEn;

    //==============================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence setWrite_s;
        clkEn && wrFire && state_ff.awAddr == OFS_CHSET
            && state_ff.wStrb[0];
    endsequence
    sequence clrWrite_s;
        clkEn && wrFire && state_ff.awAddr == OFS_CHCLR
            && state_ff.wStrb[0];
    endsequence

    swOnly_a: assert property (clkEn && state_ff.trigSel == TRG_SW
        && !swStart |=> !seqStart)
        else $error("start without software request");
    extEdge_a: assert property (clkEn && !state_ff.busy
        && state_ff.trigSel == TRG_ANY && (extRise || extFall)
        |=> seqStart && state_ff.busy)
        else $error("external edge did not start");
    periodFire_a: assert property (clkEn && !state_ff.busy
        && state_ff.trigSel == TRG_PERIOD && periodHit
        |=> seqStart && state_ff.periodCnt == 16'h0)
        else $error("periodic trigger missed");
    periodIdle_a: assert property (clkEn
        && state_ff.trigSel != TRG_PERIOD |=> state_ff.periodCnt == 0)
        else $error("timer ran outside periodic mode");
    contRun_a: assert property (clkEn && !state_ff.busy
        && state_ff.trigSel == TRG_CONT |=> seqStart)
        else $error("continuous mode stalled");
    holdLen_a: assert property (clkEn && holdStart
        |=> holdActive && state_ff.holdCnt == ($past(state_ff.holdTime)
            == 4'h0 ? HOLD_MIN : 5'($past(state_ff.holdTime)) + 5'h01))
        else $error("hold length wrong");
    chSet_a: assert property (setWrite_s |=>
        (chEnabled & $past(state_ff.wData[CH_N-1:0]))
            == $past(state_ff.wData[CH_N-1:0]))
        else $error("channel not enabled");
    chClr_a: assert property (clrWrite_s |=>
        (chEnabled & $past(state_ff.wData[CH_N-1:0])) == '0)
        else $error("channel not disabled");
    busyHold_a: assert property (clkEn && state_ff.busy
        |=> !seqStart)
        else $error("restart during sequence");
    resultLoad_a: assert property (clkEn && |convDoneIn
        |=> state_ff.resWait && state_ff.latest == $past(resultIn))
        else $error("result not captured");
    bothEmpty_a: assert property (clkEn |=>
        state_ff.bothEmpty == $past(rxCountZero && rxNextZero))
        else $error("both empty flag wrong");
    penOff_a: assert property (clkEn && !touchSenseEn
        |=> !state_ff.penMade && !state_ff.penLost)
        else $error("touch flag set while sensing off");
endmodule // tats_ctrl

//--- sim/tats_panel_model.sv
/* model of the converter and panel: one conversion per sequence start.
   assumes it shares the clock of the trigger block. */
`timescale 1ns/1ps
module tats_panel_model
    import tats_pkg::*;
(
    input wire logic clk,
    input wire logic seqStart,
    input wire logic [2:0] chSel,
    input wire logic [9:0] res,
    output logic seqDone,
    output logic [CH_N-1:0] convDoneIn,
    output logic [9:0] resultIn
);
    // ======
    // convert the chosen channel three cycles after each start
    logic [1:0] ageFf = 2'h0;
    always_ff @(posedge clk) begin
        ageFf <= {ageFf[0], seqStart};
        seqDone <= ageFf[1];
        convDoneIn <= ageFf[1] ? CH_N'(1) << chSel : '0;
        // data is junk outside the done cycle, never the held value
        resultIn <= ageFf[1] ? res : ~res;
    end
endmodule // tats_panel_model

//--- sim/touch_adc_trigger_status_test.sv
/* bench for the trigger and status block: bus tasks and scenarios.
   assumes the panel model ends each sequence a few cycles after start. */
`timescale 1ns/1ps
module touch_adc_trigger_status_test import tats_pkg::*;;
    localparam int EXPN [8] = '{0, 1, 1, 2, 1, 0, 0, 0};
    localparam int HV [3] = '{0, 1, 15};
    localparam int HE [3] = '{2, 2, 16};
    logic clk = 1'h0, reset = 1'h1, clkEn = 1'h1;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, rdV;
    logic [3:0] wstrb = 4'hF;
    logic extTrigPin = 1'h0, penTouchPin = 1'h0, touchOnlyMode = 1'h0;
    logic touchSenseEn = 1'h0, swStart = 1'h0, holdStart = 1'h0;
    logic rxCountZero = 1'h1, rxNextZero = 1'h1, rxCountWrite = 1'h0;
    logic [5:0] clockDivider = 6'h0;
    logic awready, wready, bvalid, arready, rvalid, seqDone;
    logic seqStart, holdActive, convTick;
    logic [1:0] bresp, rresp, lastResp;
    logic [CH_N-1:0] chEnabled, convDoneIn;
    logic [9:0] resultIn;
    int nMismatch = 0, nTests = 0, nStart = 0, nHold = 0;
    int cyc = 0, lastCyc = 0, gap = 0, s0;

    // ======
    // design and far side
    tats_ctrl u_dut (.clk, .reset, .clkEn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .extTrigPin, .penTouchPin, .touchOnlyMode, .touchSenseEn,
        .clockDivider, .swStart, .seqDone, .holdStart, .convDoneIn,
        .resultIn, .rxCountZero, .rxNextZero, .rxCountWrite, .seqStart,
        .holdActive, .convTick, .chEnabled);
    tats_panel_model u_panel (.clk, .seqStart, .chSel(3'h5),
        .res(10'h2A5), .seqDone, .convDoneIn, .resultIn);

    initial forever #50 clk = ~clk;
    // count starts, gaps between them and ticks inside hold windows
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (seqStart === 1'h1) begin
            nStart <= nStart + 1;
            gap <= cyc - lastCyc;
            lastCyc <= cyc;
        end
        if (holdActive === 1'h1 && convTick === 1'h1) nHold <= nHold + 1;
    end

    // ======
    // reporting
    task automatic give_verdict();
        $display("compares %0d, mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        nTests++;
        if (got !== exp) begin
            nMismatch++;
            $display("wrong value at %0t: %s %h not %h", $time, m, got, exp);
        end
    endtask
    // a wait that ran out ends the run at once
    task automatic tmo(input int k);
        if (k >= 40) begin
            nMismatch++;
            $display("wrong value at %0t: no answer", $time);
            give_verdict();
        end
    endtask

    // ======
    // bus tasks: hold each channel until its ready is sampled
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1 && k < 40);
        bready <= 1'h0;
        lastResp = bresp;
        tmo(k);
    endtask
    task automatic rd(input logic [7:0] a);
        int k;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1 && k < 40);
        rready <= 1'h0;
        rdV = rdata;
        lastResp = rresp;
        tmo(k);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rdV, e, $sformatf("read %h", a));
    endtask
    // software start held n cycles, then let the sequence finish
    task automatic kick(input int n);
        @(posedge clk);
        swStart <= 1'h1;
        repeat (n) @(posedge clk);
        swStart <= 1'h0;
        repeat (8) @(posedge clk);
    endtask
    task automatic waitStarts(input int n);
        int k;
        s0 = nStart;
        for (k = 0; k < 400 && nStart - s0 < n; k++) @(posedge clk);
        if (k >= 400) tmo(40);
    endtask

    // ======
    // scenarios
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'h0;
        rchk(OFS_STATUS, STATUS_RST);
        rchk(OFS_CHSTATE, 32'h0);
        rd(8'h40);
        chk(lastResp, RESP_SLVERR, "hole response");
        wr(8'h40, 32'h0);
        chk(lastResp, RESP_SLVERR, "hole write");
        $display("test reset done");
        // counter flags follow the pointer counters
        rxCountZero <= 1'h0;
        rxNextZero <= 1'h0;
        rxCountWrite <= 1'h1;
        @(posedge clk);
        rxCountWrite <= 1'h0;
        rchk(OFS_STATUS, 32'h0);
        rxCountZero <= 1'h1;
        rchk(OFS_STATUS, 32'h00040000);
        rxNextZero <= 1'h1;
        rchk(OFS_STATUS, 32'h000C0000);
        wr(OFS_CHSET, 32'hFFFFFF30);
        chk(lastResp, RESP_OKAY, "set response");
        rchk(OFS_CHSTATE, 32'h30);
        wr(OFS_CHCLR, 32'hFFFFFF10);
        rchk(OFS_CHSTATE, 32'h20);
        touchOnlyMode <= 1'h1;
        rchk(OFS_CHSTATE, 32'h2F);
        chk(chEnabled, 32'h20, "enables");
        $display("test channels done");
        // three conversions on channel 5 build up both overruns
        kick(1);
        rchk(OFS_STATUS, 32'h000D0020);
        rchk(OFS_LATEST, 32'h2A5);
        rchk(OFS_STATUS, 32'h000C0020);
        kick(1);
        kick(1);
        rchk(OFS_STATUS, 32'h000F2020);
        rchk(OFS_STATUS, 32'h000D0020);
        wr(OFS_CHCLR, 32'h20);
        rchk(OFS_STATUS, 32'h000D0000);
        penTouchPin <= 1'h1;
        repeat (10) @(posedge clk);
        penTouchPin <= 1'h0;
        rchk(OFS_STATUS, 32'h000D0000);
        touchSenseEn <= 1'h1;
        penTouchPin <= 1'h1;
        repeat (10) @(posedge clk);
        rchk(OFS_STATUS, 32'h001D0000);
        penTouchPin <= 1'h0;
        repeat (10) @(posedge clk);
        rchk(OFS_STATUS, 32'h002D0000);
        $display("test status done");
        // every edge and pen code, interval field set but unused
        // codes 0 to 4 only: the reserved code is never written
        for (int c = 0; c < 5; c++) begin
            wr(OFS_TRIG, 32'h00030000 | c);
            s0 = nStart;
            extTrigPin <= 1'h1;
            repeat (10) @(posedge clk);
            extTrigPin <= 1'h0;
            repeat (10) @(posedge clk);
            penTouchPin <= 1'h1;
            repeat (10) @(posedge clk);
            penTouchPin <= 1'h0;
            chk(nStart - s0, EXPN[c], "n");
        end
        wr(OFS_TRIG, 32'h0);
        s0 = nStart;
        kick(2);
        chk(nStart - s0, 1, "busy start");
        for (int i = 0; i < 3; i++) begin
            wr(OFS_HOLD, HV[i] << 24);
            s0 = nHold;
            holdStart <= 1'h1;
            @(posedge clk);
            holdStart <= 1'h0;
            repeat (40) @(posedge clk);
            chk(nHold - s0, HE[i], "hold ticks");
        end
        wr(OFS_TRIG, 32'h00030005);
        waitStarts(3);
        chk(gap, 8, "period");
        wr(OFS_TRIG, 32'h6);
        waitStarts(4);
        chk(gap <= 6, 1, "back to back");
        $display("test triggers done");
        give_verdict();
    end
endmodule // touch_adc_trigger_status_test
